// *** rtl/host_address_decoder.sv ***
// Top of the host address decoder: configuration registers on a classic
// Wishbone slave, and a one-stage routing pipeline for host and root-port
// cycles. Assumes cycles are presented on clk_i by logic of the same clock;
// the strap and the always-on-well reset arrive from pins.
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ps

module host_address_decoder #(
   parameter int unsigned NUM_PORTS = 12
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic rtc_well_reset_n_i,
   input wire logic trusted_strap_i,
   // Wishbone register slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Cycle to route
   input wire logic req_valid_i,
   input wire logic req_io_i,
   input wire logic req_from_port_i,
   input wire logic req_bridge_hit_i,
   input wire logic [31:0] req_addr_i,
   // Routing decision
   output logic dec_valid_o,
   output hub_decode_pkg::target_e dec_target_o,
   output logic [3:0] dec_port_o,
   output logic [31:0] dec_addr_o,
   output logic dec_abort_o
);
   import hub_decode_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Configuration state
   logic [14:0] fw_en_q;
   logic [31:0] io_select_q;
   logic [31:0] storage_base_q;
   logic [31:0] redirect_base_q;
   logic [31:0] apic_ctrl_q;
   logic swap_en_q;
   logic [31:0] usb_base_q;
   logic [31:0] otg_main_base_q;
   logic [31:0] otg_aux_base_q;
   logic [31:0] audio_base_q;
   logic [31:0] net_base_q;
   logic [15:0] abort_count_q;
   logic [3:0] last_target_q;

   logic rtc_sync1_q;
   logic rtc_sync2_q;
   logic strap_sync1_q;
   logic strap_sync2_q;
   logic trusted_spi_q;

   logic wr_en;
   logic rd_en;
   logic [31:0] byte_mask;
   logic [31:0] rd_data;

   logic io_hit;
   target_e io_target;
   logic mem_hit;
   target_e mem_target;
   logic [3:0] mem_port;
   target_e route_d;
   logic [31:0] addr_d;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; only the second stage is read by logic
   always_ff @(posedge clk_i) begin
      rtc_sync1_q <= rtc_well_reset_n_i;
      rtc_sync2_q <= rtc_sync1_q;
      strap_sync1_q <= trusted_strap_i;
      strap_sync2_q <= strap_sync1_q;
   end

   // Strap is sampled while platform reset is held, then frozen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trusted_spi_q <= strap_sync2_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave: single-cycle answer, ack drops the cycle after
   assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
   assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
      {8{wb_sel_i[0]}}};

   // Acknowledge every addressed cycle, mapped or not
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      end
   end

   // Firmware decode enables; bits 4 and 5 do not exist
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fw_en_q <= CFG_RESET[14:0];
      end else if (wr_en && wb_adr_i == FW_DECODE_EN_OFS) begin
         fw_en_q <= (fw_en_q & ~byte_mask[14:0]) |
            (wb_dat_i[14:0] & byte_mask[14:0] & FW_DECODE_EN_MASK);
      end
   end

   // Relocatable I/O windows: bases anywhere in the 64K space
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         io_select_q <= CFG_RESET;
         storage_base_q <= CFG_RESET;
         redirect_base_q <= CFG_RESET;
      end else if (wr_en) begin
         case (wb_adr_i)
            IO_SELECT_OFS: begin
               io_select_q <= (io_select_q & ~byte_mask) | (wb_dat_i & byte_mask);
            end
            STORAGE_BASE_OFS: begin
               storage_base_q <= (storage_base_q & ~byte_mask) | (wb_dat_i & byte_mask);
            end
            REDIRECT_BASE_OFS: begin
               redirect_base_q <= (redirect_base_q & ~byte_mask) | (wb_dat_i & byte_mask);
            end
            default: begin
            end
         endcase
      end
   end

   // Memory window controls and function base registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         apic_ctrl_q <= CFG_RESET;
         usb_base_q <= CFG_RESET;
         otg_main_base_q <= CFG_RESET;
         otg_aux_base_q <= CFG_RESET;
         audio_base_q <= CFG_RESET;
         net_base_q <= CFG_RESET;
      end else if (wr_en) begin
         case (wb_adr_i)
            APIC_CTRL_OFS: begin
               apic_ctrl_q <= (apic_ctrl_q & ~byte_mask) | (wb_dat_i & byte_mask);
            end
            USB_BASE_OFS: begin
               usb_base_q <= (usb_base_q & ~byte_mask) | (wb_dat_i & byte_mask);
            end
            OTG_MAIN_BASE_OFS: begin
               otg_main_base_q <= (otg_main_base_q & ~byte_mask) | (wb_dat_i & byte_mask);
            end
            OTG_AUX_BASE_OFS: begin
               otg_aux_base_q <= (otg_aux_base_q & ~byte_mask) | (wb_dat_i & byte_mask);
            end
            AUDIO_BASE_OFS: begin
               audio_base_q <= (audio_base_q & ~byte_mask) | (wb_dat_i & byte_mask);
            end
            NET_BASE_OFS: begin
               net_base_q <= (net_base_q & ~byte_mask) | (wb_dat_i & byte_mask);
            end
            default: begin
            end
         endcase
      end
   end

   // Swap bit lives in the always-on well: platform reset leaves it alone
   always_ff @(posedge clk_i) begin
      if (!rtc_sync2_q) begin
         swap_en_q <= 1'b0;
      end else if (wr_en && wb_adr_i == BLOCK_SWAP_OFS && wb_sel_i[0]) begin
         swap_en_q <= wb_dat_i[0];
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      rd_data = 32'h0000_0000;
      case (wb_adr_i)
         FW_DECODE_EN_OFS: rd_data = {17'h0_0000, fw_en_q};
         IO_SELECT_OFS: rd_data = io_select_q;
         STORAGE_BASE_OFS: rd_data = storage_base_q;
         REDIRECT_BASE_OFS: rd_data = redirect_base_q;
         APIC_CTRL_OFS: rd_data = apic_ctrl_q;
         BLOCK_SWAP_OFS: rd_data = {31'h0000_0000, swap_en_q};
         USB_BASE_OFS: rd_data = usb_base_q;
         OTG_MAIN_BASE_OFS: rd_data = otg_main_base_q;
         OTG_AUX_BASE_OFS: rd_data = otg_aux_base_q;
         AUDIO_BASE_OFS: rd_data = audio_base_q;
         NET_BASE_OFS: rd_data = net_base_q;
         STATUS_OFS: rd_data = {abort_count_q, 7'h00, trusted_spi_q, 4'h0, last_target_q};
         default: rd_data = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (rd_en) begin
         wb_dat_o <= rd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Window decoders; overlaps are not checked and resolve by priority
   io_window_decode u_io_decode (
      .addr_i(req_addr_i[15:0]),
      .io_select_i(io_select_q),
      .storage_base_i(storage_base_q),
      .redirect_base_i(redirect_base_q),
      .hit_o(io_hit),
      .target_o(io_target)
   );

   mem_window_decode u_mem_decode (
      .addr_i(req_addr_i),
      .fw_en_i(fw_en_q),
      .apic_ctrl_i(apic_ctrl_q),
      .trusted_spi_i(trusted_spi_q),
      .usb_base_i(usb_base_q),
      .otg_main_base_i(otg_main_base_q),
      .otg_aux_base_i(otg_aux_base_q),
      .audio_base_i(audio_base_q),
      .hit_o(mem_hit),
      .target_o(mem_target),
      .port_o(mem_port)
   );

   // Pick exactly one target from source, space and address
   always_comb begin
      route_d = TGT_ABORT;
      if (req_from_port_i) begin
         if (req_bridge_hit_i) begin
            route_d = TGT_PEER;
         end else if (net_base_q[0] && req_addr_i[31:17] == net_base_q[31:17]) begin
            route_d = TGT_NET;
         end else begin
            route_d = TGT_UPSTREAM;
         end
      end else if (req_io_i) begin
         route_d = io_hit ? io_target : TGT_ABORT;
      end else begin
         route_d = mem_hit ? mem_target : TGT_ABORT;
      end
   end

   // Block swap flips A16 for the top two 64KB firmware blocks only
   always_comb begin
      addr_d = req_addr_i;
      if (swap_en_q && route_d == TGT_FW_BUS && req_addr_i[31:17] == SWAP_PAGE) begin
         addr_d[16] = ~req_addr_i[16];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decision register: one fixed cycle of latency, accepted every cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dec_valid_o <= 1'b0;
         dec_target_o <= TGT_ABORT;
         dec_port_o <= 4'h0;
         dec_addr_o <= 32'h0000_0000;
         dec_abort_o <= 1'b0;
      end else begin
         dec_valid_o <= req_valid_i;
         dec_target_o <= route_d;
         dec_port_o <= (route_d == TGT_PORT_APIC && mem_port < NUM_PORTS) ? mem_port : 4'h0;
         dec_addr_o <= addr_d;
         dec_abort_o <= req_valid_i && route_d == TGT_ABORT;
      end
   end

   // Status: last target and a saturating abort count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         abort_count_q <= 16'h0000;
         last_target_q <= 4'h0;
      end else if (req_valid_i) begin
         last_target_q <= route_d;
         if (route_d == TGT_ABORT && abort_count_q != 16'hFFFF) begin
            abort_count_q <= abort_count_q + 16'h0001;
         end
      end
   end

endmodule : host_address_decoder

// *** rtl/hub_decode_pkg.sv ***
// Package: register map, reset values, window geometry and decode targets
// of the host address decoder.
// Assumes a 32-bit classic Wishbone register port and 32-bit cycle addresses.
package hub_decode_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] FW_DECODE_EN_OFS = 8'h00;
   localparam logic [7:0] IO_SELECT_OFS = 8'h04;
   localparam logic [7:0] STORAGE_BASE_OFS = 8'h08;
   localparam logic [7:0] REDIRECT_BASE_OFS = 8'h0C;
   localparam logic [7:0] APIC_CTRL_OFS = 8'h10;
   localparam logic [7:0] BLOCK_SWAP_OFS = 8'h14;
   localparam logic [7:0] USB_BASE_OFS = 8'h18;
   localparam logic [7:0] OTG_MAIN_BASE_OFS = 8'h1C;
   localparam logic [7:0] OTG_AUX_BASE_OFS = 8'h20;
   localparam logic [7:0] AUDIO_BASE_OFS = 8'h24;
   localparam logic [7:0] NET_BASE_OFS = 8'h28;
   localparam logic [7:0] STATUS_OFS = 8'h2C;

   // Values after platform reset: every window with an enable disabled
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [14:0] FW_DECODE_EN_MASK = 15'h7FCF;

   ////////////////////////////////////////////////////////////////////////////
   // Fixed-address windows
   localparam logic [15:0] LEGACY_E_SEG = 16'h000E;
   localparam logic [15:0] LEGACY_F_SEG = 16'h000F;
   localparam logic [11:0] APIC_PAGE_TOP = 12'hFEC;
   localparam logic [11:0] APIC_LAST_OFS = 12'h040;
   localparam logic [4:0] PORT_APIC_FIRST = 5'h02;
   localparam logic [7:0] FW_TOP_BYTE = 8'hFF;
   localparam logic [15:0] TIMER_PAGE = 16'hFED0;
   localparam logic [16:0] TRUSTED_PAGE = 17'h1FDA8;
   localparam logic [14:0] SWAP_PAGE = 15'h7FFF;
   localparam int unsigned OTG_AUX_BYTES = 24576;

   // Legacy peripheral positions, index selected by configuration
   localparam logic [15:0] SERIAL_POS [8] = '{16'h03F8, 16'h02F8, 16'h0220,
      16'h0228, 16'h0238, 16'h02E8, 16'h0338, 16'h03E8};
   localparam logic [15:0] PARALLEL_POS [3] = '{16'h0378, 16'h0278, 16'h03BC};
   localparam logic [15:0] FLOPPY_POS [2] = '{16'h03F0, 16'h0370};

   ////////////////////////////////////////////////////////////////////////////
   // Decode targets
   typedef enum logic [3:0] {
      TGT_ABORT = 4'h0,
      TGT_FW_BUS = 4'h1,
      TGT_LPC_PERIPH = 4'h2,
      TGT_STORAGE = 4'h3,
      TGT_REDIRECT = 4'h4,
      TGT_APIC = 4'h5,
      TGT_PORT_APIC = 4'h6,
      TGT_TIMER = 4'h7,
      TGT_TRUST_LPC = 4'h8,
      TGT_TRUST_SPI = 4'h9,
      TGT_USB = 4'hA,
      TGT_OTG = 4'hB,
      TGT_AUDIO = 4'hC,
      TGT_NET = 4'hD,
      TGT_UPSTREAM = 4'hE,
      TGT_PEER = 4'hF
   } target_e;

endpackage : hub_decode_pkg

// *** rtl/io_window_decode.sv ***
// Combinational decode of the relocatable I/O windows.
// Assumes registered configuration from the top level; no overlap checking.
`timescale 1ns/1ps
module io_window_decode (
   input wire logic [15:0] addr_i,
   input wire logic [31:0] io_select_i,
   input wire logic [31:0] storage_base_i,
   input wire logic [31:0] redirect_base_i,
   output logic hit_o,
   output hub_decode_pkg::target_e target_o
);
   import hub_decode_pkg::*;

   logic ser1_hit;
   logic ser2_hit;
   logic par_hit;
   logic fdd_hit;

   // Eight-byte legacy windows, each at one of its selectable positions
   assign ser1_hit = io_select_i[16] && addr_i[15:3] == SERIAL_POS[io_select_i[2:0]][15:3];
   assign ser2_hit = io_select_i[17] && addr_i[15:3] == SERIAL_POS[io_select_i[6:4]][15:3];
   // Offset compare: one parallel position is not 8-byte aligned
   assign par_hit = io_select_i[18] && io_select_i[9:8] != 2'h3 &&
      addr_i - PARALLEL_POS[io_select_i[9:8]] < 16'h0008;
   assign fdd_hit = io_select_i[19] && addr_i[15:3] == FLOPPY_POS[io_select_i[12]][15:3];

   // First match wins; overlapping setups route by this fixed priority
   always_comb begin
      hit_o = 1'b1;
      target_o = TGT_ABORT;
      if (ser1_hit || ser2_hit || par_hit || fdd_hit) begin
         target_o = TGT_LPC_PERIPH;
      end else if (storage_base_i[0] && addr_i[15:4] == storage_base_i[15:4]) begin
         target_o = TGT_STORAGE;
      end else if (redirect_base_i[0] && addr_i[15:3] == redirect_base_i[15:3]) begin
         target_o = TGT_REDIRECT;
      end else begin
         hit_o = 1'b0;
      end
   end

endmodule : io_window_decode

// *** rtl/mem_window_decode.sv ***
// Combinational decode of host memory cycles to internal targets.
// Assumes registered configuration; a miss is reported, the top aborts it.
`timescale 1ns/1ps
module mem_window_decode (
   input wire logic [31:0] addr_i,
   input wire logic [14:0] fw_en_i,
   input wire logic [31:0] apic_ctrl_i,
   input wire logic trusted_spi_i,
   input wire logic [31:0] usb_base_i,
   input wire logic [31:0] otg_main_base_i,
   input wire logic [31:0] otg_aux_base_i,
   input wire logic [31:0] audio_base_i,
   output logic hit_o,
   output hub_decode_pkg::target_e target_o,
   output logic [3:0] port_o
);
   import hub_decode_pkg::*;

   logic fw_hit;
   logic [4:0] port_slot;
   logic [31:0] aux_ofs;

   assign port_slot = addr_i[19:15] - PORT_APIC_FIRST;
   assign aux_ofs = addr_i - {otg_aux_base_i[31:13], 13'h0000};

   // Firmware windows: legacy segments, 512KB pairs, fixed top, 1MB pairs
   always_comb begin
      fw_hit = 1'b0;
      if (addr_i[31:16] == LEGACY_E_SEG) begin
         fw_hit = fw_en_i[6];
      end else if (addr_i[31:16] == LEGACY_F_SEG) begin
         fw_hit = fw_en_i[7];
      end else if (addr_i[31:24] == FW_TOP_BYTE && addr_i[23]) begin
         // Upper and lower aliases share one enable per 512KB slot for slots 0 to 6; slot 7 always hits
         fw_hit = addr_i[21:19] == 3'h7 || fw_en_i[{1'b1, addr_i[21:19]}];
      end else if (addr_i[31:24] == FW_TOP_BYTE) begin
         fw_hit = fw_en_i[addr_i[21:20]];
      end
   end

   // One target per cycle, fixed priority
   always_comb begin
      hit_o = 1'b1;
      target_o = TGT_ABORT;
      port_o = 4'h0;
      if (fw_hit) begin
         target_o = TGT_FW_BUS;
      end else if (apic_ctrl_i[8] && addr_i[31:20] == APIC_PAGE_TOP &&
            addr_i[19:12] == apic_ctrl_i[7:0] && addr_i[11:0] <= APIC_LAST_OFS) begin
         target_o = TGT_APIC;
      end else if (addr_i[31:20] == APIC_PAGE_TOP && port_slot < 5'd12 &&
            apic_ctrl_i[16 + port_slot[3:0]]) begin
         target_o = TGT_PORT_APIC;
         port_o = port_slot[3:0];
      end else if (apic_ctrl_i[28] && addr_i[31:16] == TIMER_PAGE &&
            addr_i[15:14] == 2'h0 && addr_i[13:12] == apic_ctrl_i[30:29] &&
            addr_i[11:10] == 2'h0) begin
         target_o = TGT_TIMER;
      end else if (addr_i[31:15] == TRUSTED_PAGE) begin
         target_o = trusted_spi_i ? TGT_TRUST_SPI : TGT_TRUST_LPC;
      end else if (usb_base_i[0] && addr_i[31:16] == usb_base_i[31:16]) begin
         target_o = TGT_USB;
      end else if (otg_main_base_i[0] && addr_i[31:21] == otg_main_base_i[31:21]) begin
         target_o = TGT_OTG;
      end else if (otg_aux_base_i[0] && aux_ofs < OTG_AUX_BYTES) begin
         target_o = TGT_OTG;
      end else if (audio_base_i[0] && addr_i[31:14] == audio_base_i[31:14]) begin
         target_o = TGT_AUDIO;
      end else begin
         hit_o = 1'b0;
      end
   end

endmodule : mem_window_decode

// *** tb/decoder_assertions.sv ***
// Checker: routing and register port properties of the decoder.
// Assumes it is bound to the decoder top and sees only its ports.
`timescale 1ns/1ps
module decoder_assertions
   import hub_decode_pkg::*;
#(
   parameter int unsigned NUM_PORTS = 12
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic trusted_strap_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic req_valid_i,
   input wire logic req_io_i,
   input wire logic req_from_port_i,
   input wire logic req_bridge_hit_i,
   input wire logic [31:0] req_addr_i,
   input wire logic dec_valid_o,
   input wire target_e dec_target_o,
   input wire logic dec_abort_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ////////////////////////////////////////////////////////////////////////////
   // Host memory cycle inside a range, and a root-port cycle
   sequence host_mem_s(logic [31:0] lo, logic [31:0] hi);
      req_valid_i && !req_io_i && !req_from_port_i && req_addr_i >= lo && req_addr_i <= hi;
   endsequence
   sequence port_cyc_s;
      req_valid_i && req_from_port_i;
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   valid_latency_a: assert property (
      !$past(rst_i) |-> dec_valid_o == $past(req_valid_i)) else $error("valid latency");
   abort_flag_a: assert property (
      dec_abort_o == (dec_valid_o && dec_target_o == TGT_ABORT)) else $error("abort flag");
   peer_reserved_a: assert property (
      port_cyc_s ##0 req_bridge_hit_i |=> dec_target_o == TGT_PEER) else $error("peer");
   port_forward_a: assert property (
      port_cyc_s ##0 !req_bridge_hit_i |=> dec_target_o inside {TGT_NET, TGT_UPSTREAM})
      else $error("port forward");
   fw_always_a: assert property (
      host_mem_s(32'hFFF8_0000, 32'hFFFF_FFFF) or host_mem_s(32'hFFB8_0000, 32'hFFBF_FFFF)
      |=> dec_target_o == TGT_FW_BUS) else $error("top firmware range");
   trusted_route_a: assert property (
      host_mem_s(32'hFED4_0000, 32'hFED4_7FFF) |=>
      dec_target_o == (trusted_strap_i ? TGT_TRUST_SPI : TGT_TRUST_LPC)) else $error("trusted");
   legacy_gate_a: assert property (
      host_mem_s(32'h000E_0000, 32'h000F_FFFF) |=> dec_target_o inside {TGT_FW_BUS, TGT_ABORT})
      else $error("legacy segment");
   wb_ack_a: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("ack");
endmodule : decoder_assertions

bind host_address_decoder decoder_assertions #(.NUM_PORTS(NUM_PORTS)) u_decoder_assertions (.*);

// *** tb/host_link_model.sv ***
// Host side of the decoder: presents one routed cycle per call.
// Assumes a single caller process on the decoder clock.
`timescale 1ns/1ps
module host_link_model (
   input wire logic clk_i,
   output logic req_valid_o,
   output logic req_io_o,
   output logic req_from_port_o,
   output logic req_bridge_hit_o,
   output logic [31:0] req_addr_o
);
   // Idle link at time zero
   initial begin
      req_valid_o = 1'b0;
      req_io_o = 1'b0;
      req_from_port_o = 1'b0;
      req_bridge_hit_o = 1'b0;
      req_addr_o = 32'h0000_0000;
   end

   // One cycle for one clock; plain accesses only, never locked ones
   task automatic issue(input logic io, input logic port, input logic br, input logic [31:0] a);
      @(posedge clk_i);
      req_valid_o <= 1'b1;
      req_io_o <= io;
      req_from_port_o <= port;
      req_bridge_hit_o <= br;
      req_addr_o <= a;
      @(posedge clk_i);
      req_valid_o <= 1'b0;
      req_addr_o <= ~a; // Released address shows garbage, not the old value
   endtask : issue
endmodule : host_link_model

// *** tb/test_host_address_decoder.sv ***
// Testbench: register port, memory, I/O and root-port routing, block swap.
// Assumes the decoder package and the host link model are compiled first.
`timescale 1ns/1ps
module test_host_address_decoder;
   import hub_decode_pkg::*;
   localparam logic [31:0] TA [4] = '{32'hC000_0000, 32'hD000_0000, 32'hE000_0000, 32'hE100_0000};
   localparam target_e TT [4] = '{TGT_USB, TGT_OTG, TGT_OTG, TGT_AUDIO};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic rtc_n = 1'b1;
   logic strap = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic swp = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, rd, addr, daddr;
   logic ack, valid, io, port, br, dvalid, dabort;
   logic [3:0] dport;
   logic [14:0] fw = 15'h0;
   logic [31:0] ap = 32'h0;
   target_e dtgt;
   int fail_count = 0;
   int checked = 0;

   host_address_decoder u_host_address_decoder (.clk_i(clk_i), .rst_i(rst_i),
      .rtc_well_reset_n_i(rtc_n), .trusted_strap_i(strap), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .req_valid_i(valid), .req_io_i(io), .req_from_port_i(port),
      .req_bridge_hit_i(br), .req_addr_i(addr), .dec_valid_o(dvalid), .dec_target_o(dtgt),
      .dec_port_o(dport), .dec_addr_o(daddr), .dec_abort_o(dabort));
   host_link_model u_host_link_model (.clk_i(clk_i), .req_valid_o(valid), .req_io_o(io),
      .req_from_port_o(port), .req_bridge_hit_o(br), .req_addr_o(addr));

   always #2.5 clk_i = ~clk_i;

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Classic single cycle; request held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      chk("ack", ack, 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   // Route one cycle, then compare the registered decision
   task automatic dec(input logic i, input logic p, input logic b, input logic [31:0] a,
      input target_e t);
      logic sw;
      sw = swp && t == TGT_FW_BUS && a[31:17] == SWAP_PAGE;
      u_host_link_model.issue(i, p, b, a);
      #1;
      chk("valid", dvalid, 1'b1);
      chk("target", dtgt, t);
      chk("abort", dabort, t == TGT_ABORT);
      chk("addr", daddr, sw ? a ^ 32'h0001_0000 : a);
   endtask : dec

   // Expected target of a host memory cycle under the current settings
   function automatic target_e exp_mem(input logic [31:0] a);
      if (a[31:17] == 15'h0007) return fw[6 + a[16]] ? TGT_FW_BUS : TGT_ABORT;
      if (a[31:24] == 8'hFF) return (a[23] ? (a[21:19] == 3'h7 || fw[8 + a[21:19]])
         : fw[a[21:20]]) ? TGT_FW_BUS : TGT_ABORT;
      if (a[31:20] == 12'hFEC && ap[8] && a[19:12] == ap[7:0] && a[11:0] <= 12'h040)
         return TGT_APIC;
      if (a[31:20] == 12'hFEC && a[19:15] inside {[2:13]} && ap[14 + a[19:15]])
         return TGT_PORT_APIC;
      if (a[31:16] == 16'hFED0 && ap[28] && a[15:10] == {2'h0, ap[30:29], 2'h0}) return TGT_TIMER;
      if (a[31:15] == 17'h1FDA8) return strap ? TGT_TRUST_SPI : TGT_TRUST_LPC;
      return TGT_ABORT;
   endfunction : exp_mem

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   // Hang guard, well beyond the few thousand cycles the run needs
   initial begin
      #100_000;
      fail_count++;
      stop_test;
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] a;
      target_e t;
      a = $urandom(53231);
      rtc_n = 1'b0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rtc_n <= 1'b1;
      for (int o = 0; o <= 8'h30; o += 4) begin
         wb('0, 8'(o), 32'h0);
         chk("reset reg", rd, 32'h0);
      end
      wb('1, 8'h30, 32'hFFFF_FFFF);
      wb('0, 8'h30, 32'h0);
      chk("unmapped", rd, 32'h0);
      wb('1, FW_DECODE_EN_OFS, 32'hFFFF_FFFF);
      wb('0, FW_DECODE_EN_OFS, 32'h0);
      chk("fw enable", rd, 32'h0000_7FCF);
      wb('1, FW_DECODE_EN_OFS, 32'h0);
      dec('0, '0, '0, 32'hFFBF_FFFF, TGT_FW_BUS);
      dec('0, '0, '0, 32'h0000_1000, TGT_ABORT);
      // Random enables against every fixed memory window
      for (int k = 0; k < 150; k++) begin
         fw = 15'($urandom);
         ap = $urandom & 32'h7FFF_01FF;
         ap[7:0] = 8'($urandom_range(255, 112));
         wb('1, FW_DECODE_EN_OFS, {17'h0, fw});
         wb('1, APIC_CTRL_OFS, ap);
         for (int j = 0; j < 6; j++) begin
            case ($urandom_range(5, 0))
               0: a = {12'h000, 4'($urandom_range(15, 14)), 16'($urandom)};
               1: a = {8'hFF, 24'($urandom)};
               2: a = {12'hFEC, ap[7:0], 12'($urandom_range(68, 0))};
               3: a = 32'hFEC1_0000 + 32'($urandom_range(32'h5FFFF, 0));
               4: a = {16'hFED0, 16'($urandom_range(16'h4FFF, 0))};
               default: a = {16'hFED4, 16'($urandom)};
            endcase
            t = exp_mem(a);
            dec('0, '0, '0, a, t);
            chk("port", dport, t == TGT_PORT_APIC ? 32'(a[19:15] - 5'd2) : 32'h0);
         end
      end
      // Legacy windows, kept clear of the fixed I/O ranges
      for (int i = 0; i < 8; i++) begin
         wb('1, IO_SELECT_OFS, i[0] ? 32'h0002_0000 | i << 4 : 32'h0001_0000 | i);
         dec('1, '0, '0, {16'h0, SERIAL_POS[i] + 16'h7}, TGT_LPC_PERIPH);
         dec('1, '0, '0, {16'h0, SERIAL_POS[i] + 16'h8}, TGT_ABORT);
         if (i < 3) begin
            wb('1, IO_SELECT_OFS, i < 2 ? 32'h0008_0000 | i << 12 : 32'h0004_0000 | i << 8);
            a = {16'h0, i < 2 ? FLOPPY_POS[i] : PARALLEL_POS[i]};
            dec('1, '0, '0, a + 32'h7, TGT_LPC_PERIPH);
         end
      end
      wb('1, STORAGE_BASE_OFS, 32'h0000_FFF1);
      dec('1, '0, '0, 32'h0000_FFFF, TGT_STORAGE);
      dec('1, '0, '0, 32'h0000_FFEF, TGT_ABORT);
      wb('1, REDIRECT_BASE_OFS, 32'h0000_1009);
      dec('1, '0, '0, 32'h0000_100F, TGT_REDIRECT);
      dec('1, '0, '0, 32'h0000_1010, TGT_ABORT);
      wb('1, NET_BASE_OFS, 32'hA000_0001);
      dec('0, '1, '1, 32'hA000_0000, TGT_PEER);
      dec('0, '1, '0, 32'hA001_FFFF, TGT_NET);
      dec('0, '1, '0, 32'hA002_0000, TGT_UPSTREAM);
      // Function bases sit at consecutive word offsets from the USB base
      for (int i = 0; i < 4; i++) begin
         dec('0, '0, '0, TA[i] + 32'h10, TGT_ABORT);
         wb('1, USB_BASE_OFS + 8'(4 * i), TA[i] | 32'h1);
         dec('0, '0, '0, TA[i] + 32'h10, TT[i]);
      end
      // Swap survives platform reset, only the always-on reset clears it
      wb('1, BLOCK_SWAP_OFS, 32'h1);
      swp = 1'b1;
      dec('0, '0, '0, 32'hFFFE_0010, TGT_FW_BUS);
      dec('0, '0, '0, 32'hFFFD_0010, TGT_FW_BUS);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      wb('0, BLOCK_SWAP_OFS, 32'h0);
      chk("swap kept", rd, 32'h1);
      wb('0, USB_BASE_OFS, 32'h0);
      chk("base cleared", rd, 32'h0);
      dec('0, '0, '0, 32'hFFFF_1234, TGT_FW_BUS);
      @(posedge clk_i);
      rtc_n <= 1'b0;
      repeat (4) @(posedge clk_i);
      rtc_n <= 1'b1;
      repeat (4) @(posedge clk_i);
      wb('0, BLOCK_SWAP_OFS, 32'h0);
      chk("swap cleared", rd, 32'h0);
      swp = 1'b0;
      dec('0, '0, '0, 32'hFFFF_1234, TGT_FW_BUS);
      stop_test;
   end
endmodule : test_host_address_decoder
